// ---- src/audio_power_reset_control.sv ----
`timescale 1ns/1ps
// Overview of operation
// - analog supply 3v3 switched by 0xa06f
// - digital supply 1v8 switched by 0xa06e
// - power-up holds audio reset, then releases
// - reset bit in 0xa038 restarts audio reset
// - enable bit in 0xa038; disabled means low power
// - disabled: clock stopped outside reset hold, registers locked, preserved
// - power removal discards the audio register bank; clock config and control bits survive
// - bias pins double as mic clock, select
// - positive mic inputs double as mic data
// - write-one bits clear or act on one
module audio_power_reset_control
    import audio_power_pkg::*;
#(
    parameter logic [15:0] RESET_HOLD = 16'(RESET_HOLD_CYCLES),
    parameter logic [7:0] DMIC_HALF = 8'(DMIC_HALF_CYCLES)
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input audio_power_pkg::reg_req_t i_reg_req,
    input wire logic i_digital_mic_data_first,
    input wire logic i_digital_mic_data_second,
    output logic [7:0] o_reg_rdata,
    output logic o_analog_supply_3v3_en,
    output logic o_digital_supply_1v8_en,
    output logic [7:0] o_audio_clock_config,
    output logic o_audio_reset,
    output logic o_audio_clock_en,
    output audio_power_pkg::mic_pins_t o_mic_pins
);
    import audio_power_pkg::*;

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        logic [7:0] clock_cfg;
        logic ctrl_enable;
        logic dmic_mode;
        logic dmic_sel;
        logic supply_1v8;
        logic supply_3v3;
        seq_state_t seq;
        logic [15:0] hold_cnt;
        logic [7:0] div_cnt;
        logic dmic_clk;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] sync3;
        logic [1:0] mic_filt;
        logic [1:0] mic_data;
        logic [7:0] rdata;
        logic audio_reset;
        logic audio_clk_en;
        mic_pins_t pins;
    } ctrl_state_t;

    localparam ctrl_state_t STATE_RESET = '{
        clock_cfg: REG_RESET_VALUE,
        seq: SEQ_OFF,
        audio_reset: 1'b1,
        default: '0
    };

    ctrl_state_t state_r;
    ctrl_state_t state_nxt;
    logic [7:0] bank_rdata;
    logic bank_wr;
    logic bank_clear;

    function automatic logic in_bank(input logic [15:0] addr);
        return addr >= BANK_BASE_ADDR && addr < BANK_BASE_ADDR + 16'(BANK_DEPTH);
    endfunction : in_bank

    function automatic logic [7:0] bank_index(input logic [15:0] addr);
        return 8'(addr - BANK_BASE_ADDR);
    endfunction : bank_index

    // ********************************************************************
    // audio register bank
    // ********************************************************************
    audio_reg_bank #(
        .DEPTH(BANK_DEPTH)
    ) u_bank (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clear(bank_clear),
        .i_wr_en(bank_wr),
        .i_index(bank_index(i_reg_req.addr)),
        .i_wdata(i_reg_req.wdata),
        .o_rdata(bank_rdata)
    );

    // ********************************************************************
    // next state
    // ********************************************************************
    logic powered;
    logic access_ok;
    logic reset_req;
    logic [7:0] ctrl_view;

    always_comb begin
        state_nxt = state_r;
        powered = state_r.supply_1v8 && state_r.supply_3v3;
        // only a running, enabled, powered audio block takes bank accesses
        access_ok = state_r.seq == SEQ_RUN && state_r.ctrl_enable;
        reset_req = i_reg_req.wr && i_reg_req.addr == CONTROL_ADDR
            && i_reg_req.wdata[CTRL_RESET_BIT];
        bank_wr = i_reg_req.wr && in_bank(i_reg_req.addr) && access_ok;
        bank_clear = state_r.seq != SEQ_RUN;
        ctrl_view = '0;
        ctrl_view[CTRL_ENABLE_BIT] = state_r.ctrl_enable;
        ctrl_view[CTRL_DMIC_MODE_BIT] = state_r.dmic_mode;
        ctrl_view[CTRL_DMIC_SEL_BIT] = state_r.dmic_sel;
        ctrl_view[CTRL_IN_RESET_BIT] = state_r.audio_reset;
        ctrl_view[CTRL_POWERED_BIT] = powered;
        ctrl_view[CTRL_MIC_DATA_LSB +: 2] = state_r.mic_data;

        if (i_reg_req.wr) begin
            case (i_reg_req.addr)
                CLOCK_CONFIG_ADDR: begin
                    // must be set before the supplies come up
                    state_nxt.clock_cfg = i_reg_req.wdata;
                end
                CONTROL_ADDR: begin
                    state_nxt.ctrl_enable = i_reg_req.wdata[CTRL_ENABLE_BIT];
                    state_nxt.dmic_mode = i_reg_req.wdata[CTRL_DMIC_MODE_BIT];
                    state_nxt.dmic_sel = i_reg_req.wdata[CTRL_DMIC_SEL_BIT];
                end
                DIGITAL_SUPPLY_ADDR: begin
                    state_nxt.supply_1v8 = i_reg_req.wdata[SUPPLY_ON_BIT];
                end
                ANALOG_SUPPLY_ADDR: begin
                    state_nxt.supply_3v3 = i_reg_req.wdata[SUPPLY_ON_BIT];
                end
                default: begin
                end
            endcase
        end

        // ****************************************************************
        // reset sequencer
        // ****************************************************************
        case (state_r.seq)
            SEQ_OFF: begin
                state_nxt.hold_cnt = '0;
                if (powered) begin
                    state_nxt.seq = SEQ_HOLD;
                end
            end
            SEQ_HOLD: begin
                if (!powered) begin
                    state_nxt.seq = SEQ_OFF;
                end else if (reset_req) begin
                    state_nxt.hold_cnt = '0;
                end else if (state_r.hold_cnt >= RESET_HOLD - 16'd1) begin
                    state_nxt.seq = SEQ_RUN;
                end else begin
                    state_nxt.hold_cnt = state_r.hold_cnt + 16'd1;
                end
            end
            SEQ_RUN: begin
                if (!powered) begin
                    state_nxt.seq = SEQ_OFF;
                end else if (reset_req) begin
                    state_nxt.seq = SEQ_HOLD;
                    state_nxt.hold_cnt = '0;
                end
            end
            default: begin
                state_nxt.seq = SEQ_OFF;
            end
        endcase
        state_nxt.audio_reset = state_nxt.seq != SEQ_RUN;
        // clock runs during the reset hold so the logic really resets
        state_nxt.audio_clk_en = state_nxt.seq == SEQ_HOLD
            || (state_nxt.seq == SEQ_RUN && state_nxt.ctrl_enable);

        // ****************************************************************
        // digital microphone clock and data
        // ****************************************************************
        state_nxt.sync1 = {i_digital_mic_data_second, i_digital_mic_data_first};
        state_nxt.sync2 = state_r.sync1;
        state_nxt.sync3 = state_r.sync2;
        for (int i = 0; i < 2; i++) begin
            if (state_r.sync2[i] == state_r.sync3[i]) begin
                state_nxt.mic_filt[i] = state_r.sync3[i];
            end
        end
        if (state_r.audio_clk_en && state_r.dmic_mode && !state_r.audio_reset) begin
            if (state_r.div_cnt >= DMIC_HALF - 8'd1) begin
                state_nxt.div_cnt = '0;
                state_nxt.dmic_clk = !state_r.dmic_clk;
                // sample on the rising edge of the outgoing mic clock
                if (!state_r.dmic_clk) begin
                    state_nxt.mic_data = state_r.mic_filt;
                end
            end else begin
                state_nxt.div_cnt = state_r.div_cnt + 8'd1;
            end
        end else begin
            state_nxt.div_cnt = '0;
            state_nxt.dmic_clk = 1'b0;
        end
        // bias and digital functions never drive a pin at once
        state_nxt.pins.left_mic_bias_en = state_nxt.audio_clk_en && !state_nxt.dmic_mode;
        state_nxt.pins.right_mic_bias_en = state_nxt.audio_clk_en && !state_nxt.dmic_mode;
        state_nxt.pins.digital_mic_clock = state_nxt.dmic_mode && state_nxt.dmic_clk;
        state_nxt.pins.digital_mic_select = state_nxt.dmic_mode && state_nxt.dmic_sel;

        // ****************************************************************
        // register read
        // ****************************************************************
        if (i_reg_req.rd) begin
            case (i_reg_req.addr)
                CLOCK_CONFIG_ADDR: state_nxt.rdata = state_r.clock_cfg;
                CONTROL_ADDR: state_nxt.rdata = ctrl_view;
                DIGITAL_SUPPLY_ADDR: state_nxt.rdata = {7'h00, state_r.supply_1v8};
                ANALOG_SUPPLY_ADDR: state_nxt.rdata = {7'h00, state_r.supply_3v3};
                default: begin
                    state_nxt.rdata = (in_bank(i_reg_req.addr) && access_ok)
                        ? bank_rdata : 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_r <= STATE_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    assign o_reg_rdata = state_r.rdata;
    assign o_analog_supply_3v3_en = state_r.supply_3v3;
    assign o_digital_supply_1v8_en = state_r.supply_1v8;
    assign o_audio_clock_config = state_r.clock_cfg;
    assign o_audio_reset = state_r.audio_reset;
    assign o_audio_clock_en = state_r.audio_clk_en;
    assign o_mic_pins = state_r.pins;
endmodule : audio_power_reset_control

// ---- pkg/audio_power_pkg.sv ----
package audio_power_pkg;

    // ********************************************************************
    // register addresses
    // ********************************************************************
    localparam logic [15:0] CLOCK_CONFIG_ADDR = 16'ha037;
    localparam logic [15:0] CONTROL_ADDR = 16'ha038;
    localparam logic [15:0] DIGITAL_SUPPLY_ADDR = 16'ha06e;
    localparam logic [15:0] ANALOG_SUPPLY_ADDR = 16'ha06f;
    localparam logic [15:0] BANK_BASE_ADDR = 16'ha100;
    localparam int BANK_DEPTH = 240;

    // ********************************************************************
    // field positions and reset values
    // ********************************************************************
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_RESET_BIT = 1;
    localparam int CTRL_DMIC_MODE_BIT = 2;
    localparam int CTRL_DMIC_SEL_BIT = 3;
    localparam int CTRL_IN_RESET_BIT = 4;
    localparam int CTRL_POWERED_BIT = 5;
    localparam int CTRL_MIC_DATA_LSB = 6;
    localparam int SUPPLY_ON_BIT = 0;
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    // ********************************************************************
    // timing
    // ********************************************************************
    localparam int CLOCK_HZ = 25000000;
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int RESET_HOLD_NS = 1000;
    localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int DMIC_CLOCK_HZ = 2500000;
    localparam int DMIC_HALF_CYCLES = CLOCK_HZ / (2 * DMIC_CLOCK_HZ);

    // ********************************************************************
    // types
    // ********************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic left_mic_bias_en;
        logic right_mic_bias_en;
        logic digital_mic_clock;
        logic digital_mic_select;
    } mic_pins_t;

    typedef enum logic [1:0] {
        SEQ_OFF = 2'b00,
        SEQ_HOLD = 2'b01,
        SEQ_RUN = 2'b10
    } seq_state_t;

endpackage : audio_power_pkg

// ---- src/audio_reg_bank.sv ----
`timescale 1ns/1ps
module audio_reg_bank #(
    parameter int DEPTH = 240
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_wr_en,
    input wire logic [7:0] i_index,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    import audio_power_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } bank_state_t;

    bank_state_t state_r;
    bank_state_t state_nxt;
    logic in_range;

    assign in_range = 32'(i_index) < DEPTH;
    assign o_rdata = in_range ? state_r.mem[i_index] : 8'h00;

    always_comb begin
        state_nxt = state_r;
        // contents are volatile: lost whenever the audio logic is unpowered or reset
        if (i_clear) begin
            state_nxt = '0;
        end else if (i_wr_en && in_range) begin
            state_nxt.mem[i_index] = i_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule : audio_reg_bank

// ---- verification/audio_power_sva.sv ----
`timescale 1ns/1ps
module audio_power_sva
    import audio_power_pkg::*;
#(
    parameter logic [15:0] RESET_HOLD = 16'h0019
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input audio_power_pkg::reg_req_t i_reg_req,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_analog_supply_3v3_en,
    input wire logic o_digital_supply_1v8_en,
    input wire logic [7:0] o_audio_clock_config,
    input wire logic o_audio_reset,
    input wire logic o_audio_clock_en
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic on;
    logic wr_ctl;
    logic [15:0] hold_cnt;
    assign on = o_analog_supply_3v3_en && o_digital_supply_1v8_en;
    assign wr_ctl = i_reg_req.wr && i_reg_req.addr == CONTROL_ADDR;
    // hold is too long for a repetition, so count it; only clocked reset cycles count,
    // so time spent unpowered cannot mask a short hold
    always_ff @(posedge i_clock) begin
        if (i_rst || !(o_audio_reset && o_audio_clock_en)) begin
            hold_cnt <= 16'h0000;
        end else if (hold_cnt != 16'hffff) begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end
    AST_ANALOG_SUPPLY: assert property (i_reg_req.wr && i_reg_req.addr == ANALOG_SUPPLY_ADDR
        |=> o_analog_supply_3v3_en == $past(i_reg_req.wdata[SUPPLY_ON_BIT]))
        else $error("analog supply enable wrong");
    AST_DIGITAL_SUPPLY: assert property (i_reg_req.wr && i_reg_req.addr == DIGITAL_SUPPLY_ADDR
        |=> o_digital_supply_1v8_en == $past(i_reg_req.wdata[SUPPLY_ON_BIT]))
        else $error("digital supply enable wrong");
    AST_CLOCK_CONFIG: assert property (i_reg_req.wr && i_reg_req.addr == CLOCK_CONFIG_ADDR
        |=> o_audio_clock_config == $past(i_reg_req.wdata)) else $error("clock config wrong");
    AST_RESET_HOLD: assert property ($fell(o_audio_reset) |-> hold_cnt >= RESET_HOLD)
        else $error("audio reset released early");
    AST_RESET_RELEASE: assert property ($rose(on) |-> ##[1:40] (!o_audio_reset || !on))
        else $error("audio reset never released");
    AST_RESET_BIT: assert property (wr_ctl && i_reg_req.wdata[CTRL_RESET_BIT] && on
        |-> ##[1:2] o_audio_reset) else $error("reset bit did not reset");
    AST_DISABLE: assert property (wr_ctl && !i_reg_req.wdata[CTRL_ENABLE_BIT]
        && !i_reg_req.wdata[CTRL_RESET_BIT] && !o_audio_reset |-> ##[1:2] !o_audio_clock_en)
        else $error("disable left clock running");
    AST_POWER_LOSS: assert property (!on ##1 !on |-> o_audio_reset)
        else $error("unpowered audio not in reset");
    AST_BANK_LOCK: assert property (i_reg_req.rd && o_audio_reset
        && i_reg_req.addr[15:8] == BANK_BASE_ADDR[15:8] |=> o_reg_rdata == 8'h00)
        else $error("locked bank read not zero");
endmodule : audio_power_sva
bind audio_power_reset_control audio_power_sva #(.RESET_HOLD(RESET_HOLD)) u_audio_power_sva (
    .i_clock(i_clock), .i_rst(i_rst), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
    .o_analog_supply_3v3_en(o_analog_supply_3v3_en),
    .o_digital_supply_1v8_en(o_digital_supply_1v8_en),
    .o_audio_clock_config(o_audio_clock_config), .o_audio_reset(o_audio_reset),
    .o_audio_clock_en(o_audio_clock_en));

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
    import audio_power_pkg::*;
    localparam logic [15:0] SLOT = BANK_BASE_ADDR + 16'h0005;
    logic clock = 1'b0;
    logic rst = 1'b1;
    reg_req_t req = '0;
    logic mic_a = 1'b0;
    logic mic_b = 1'b0;
    logic [7:0] rdata;
    logic [7:0] cfg;
    logic ana_en;
    logic dig_en;
    logic aud_rst;
    logic clk_en;
    mic_pins_t pins;
    logic [31:0] seed = 32'h1803;
    logic [15:0] exp_q[$];
    logic rd_pend = 1'b0;
    logic [7:0] saved;
    logic last;
    int toggles;
    int failures = 0;
    int samples_checked = 0;

    always #20 clock = ~clock;

    audio_power_reset_control #(.RESET_HOLD(16'h0002), .DMIC_HALF(8'h01))
        u_audio_power_reset_control (.i_clock(clock), .i_rst(rst), .i_reg_req(req),
        .i_digital_mic_data_first(mic_a), .i_digital_mic_data_second(mic_b),
        .o_reg_rdata(rdata), .o_analog_supply_3v3_en(ana_en), .o_digital_supply_1v8_en(dig_en),
        .o_audio_clock_config(cfg), .o_audio_reset(aud_rst), .o_audio_clock_en(clk_en),
        .o_mic_pins(pins));

    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        samples_checked++;
        if (seen !== expd) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : check

    task automatic give_verdict;
        // a read whose answer never showed up is a mismatch too
        if (exp_q.size() != 0) begin
            failures++;
        end
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clock);
        req <= '0;
    endtask : access

    // note holds the mask of defined bits above the expected value
    task automatic rd_exp(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
        exp_q.push_back({m, e});
        access(1'b0, a, 8'h00);
    endtask : rd_exp

    task automatic wait_rst(input logic lvl);
        int n = 0;
        while (aud_rst !== lvl && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (n >= 100) begin
            failures++;
            give_verdict();
        end
    endtask : wait_rst

    // ****************
    // read data monitor
    // ****************
    always @(posedge clock) rd_pend <= req.rd && !rst;
    always @(negedge clock) begin
        logic [15:0] ent;
        if (rd_pend && exp_q.size() > 0) begin
            ent = exp_q.pop_front();
            check(rdata & ent[15:8], ent[7:0]);
        end
    end

    // ****************
    // scenarios
    // ****************
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rd_exp(CLOCK_CONFIG_ADDR, 8'hff, 8'h00);
        rd_exp(CONTROL_ADDR, 8'h3f, 8'h10);
        rd_exp(DIGITAL_SUPPLY_ADDR, 8'hff, 8'h00);
        rd_exp(ANALOG_SUPPLY_ADDR, 8'hff, 8'h00);
        rd_exp(16'ha0ff, 8'hff, 8'h00);
        access(1'b1, SLOT, 8'h5a);
        rd_exp(SLOT, 8'hff, 8'h00);
        repeat (3) begin
            seed = xorshift(seed);
            mic_a <= seed[9];
            access(1'b1, CLOCK_CONFIG_ADDR, seed[7:0]);
            rd_exp(CLOCK_CONFIG_ADDR, 8'hff, seed[7:0]);
            check(cfg, seed[7:0]);
        end
        access(1'b1, DIGITAL_SUPPLY_ADDR, 8'hff);
        access(1'b1, ANALOG_SUPPLY_ADDR, 8'h01);
        rd_exp(DIGITAL_SUPPLY_ADDR, 8'hff, 8'h01);
        check({6'h00, ana_en, dig_en}, 8'h03);
        wait_rst(1'b0);
        rd_exp(CONTROL_ADDR, 8'h3f, 8'h20);
        access(1'b1, CONTROL_ADDR, 8'h01);
        seed = xorshift(seed);
        saved = seed[7:0];
        access(1'b1, SLOT, saved);
        rd_exp(SLOT, 8'hff, saved);
        check({7'h00, clk_en}, 8'h01);
        access(1'b1, CONTROL_ADDR, 8'h00);
        access(1'b1, SLOT, ~saved);
        rd_exp(SLOT, 8'hff, 8'h00);
        check({7'h00, clk_en}, 8'h00);
        mic_a <= 1'b1;
        mic_b <= 1'b0;
        access(1'b1, CONTROL_ADDR, 8'h0d);
        toggles = 0;
        last = pins.digital_mic_clock;
        repeat (16) begin
            @(posedge clock);
            if (pins.digital_mic_clock !== last) toggles++;
            last = pins.digital_mic_clock;
        end
        rd_exp(SLOT, 8'hff, saved);
        rd_exp(CONTROL_ADDR, 8'hcc, 8'h4c);
        check({pins.digital_mic_select, pins.left_mic_bias_en, 5'h00, toggles > 0}, 8'h81);
        access(1'b1, CONTROL_ADDR, 8'h01);
        repeat (3) @(posedge clock);
        check({6'h00, pins.left_mic_bias_en, pins.right_mic_bias_en}, 8'h03);
        access(1'b1, CONTROL_ADDR, 8'h03);
        wait_rst(1'b1);
        wait_rst(1'b0);
        access(1'b1, CONTROL_ADDR, 8'h01);
        rd_exp(SLOT, 8'hff, 8'h00);
        rd_exp(CONTROL_ADDR, 8'h02, 8'h00);
        access(1'b1, SLOT, saved);
        access(1'b1, ANALOG_SUPPLY_ADDR, 8'h00);
        repeat (2) @(posedge clock);
        check({7'h00, aud_rst}, 8'h01);
        access(1'b1, ANALOG_SUPPLY_ADDR, 8'h01);
        wait_rst(1'b0);
        access(1'b1, CONTROL_ADDR, 8'h01);
        rd_exp(SLOT, 8'hff, 8'h00);
        repeat (3) @(posedge clock);
        give_verdict();
    end
endmodule : tb
